/* File: rtl/vpl_lookup_top.v */
// palette lookup converter: colour table, host index/data port, pixel path
// assumes host strobes and pixels come from logic on clock_i
`timescale 1ns/1ps
`include "vpl_regs.vh"

module vpl_lookup_top #(
   parameter ENTRIES = 256,
   parameter CURSOR_ENTRIES = 8,
   parameter FIFO_DEPTH = 16,
   parameter FIFO_AW = 4
) (
   input wire clock_i,
   input wire sys_rst_i,
   input wire [15:0] io_addr_i,
   input wire io_mem_space_i,
   input wire io_wr_i,
   input wire io_rd_i,
   input wire [7:0] io_wdata_i,
   output reg [7:0] io_rdata_o,
   output reg io_rvalid_o,
   input wire cursor_select_i,
   input wire direct_mode_i,
   input wire pix_valid_i,
   output wire pix_ready_o,
   input wire [23:0] pix_data_i,
   output reg dac_valid_o,
   input wire dac_ready_i,
   output reg [7:0] dac_red_o,
   output reg [7:0] dac_green_o,
   output reg [7:0] dac_blue_o
);

   // ========================================================================
   // helper functions
   // ========================================================================

   // address match; the data port moves to another offset in memory space
   function addr_hit;
      input [15:0] addr;
      input mem_space;
      input [15:0] io_port;
      input [15:0] mem_port;
      begin
         addr_hit = mem_space ? (addr == mem_port) : (addr == io_port);
      end
   endfunction

   // pick one colour byte of an entry by sequencer step
   function [7:0] pick_byte;
      input [23:0] entry;
      input [1:0] step;
      begin
         case (step)
            `VPL_SEQ_RED: pick_byte = entry[`VPL_RED_LSB +: 8];
            `VPL_SEQ_GREEN: pick_byte = entry[`VPL_GREEN_LSB +: 8];
            `VPL_SEQ_BLUE: pick_byte = entry[`VPL_BLUE_LSB +: 8];
            default: pick_byte = 8'h00;
         endcase
      end
   endfunction

   // ========================================================================
   // host port decode
   // ========================================================================
   wire hit_mask; // pixel mask register
   wire hit_rd_idx; // read index / state register
   wire hit_wr_idx; // write index register
   wire hit_data; // colour data port
   wire do_wr; // write strobe, takes priority over a read
   wire do_rd; // read strobe when no write is pending

   assign hit_mask = addr_hit(io_addr_i, io_mem_space_i,
                              `VPL_ADDR_MASK, `VPL_ADDR_MASK);
   assign hit_rd_idx = addr_hit(io_addr_i, io_mem_space_i,
                                `VPL_ADDR_RD_IDX, `VPL_ADDR_RD_IDX);
   assign hit_wr_idx = addr_hit(io_addr_i, io_mem_space_i,
                                `VPL_ADDR_WR_IDX, `VPL_ADDR_WR_IDX);
   assign hit_data = addr_hit(io_addr_i, io_mem_space_i,
                              `VPL_ADDR_DATA_IO, `VPL_ADDR_DATA_MEM);
   // a read and a write in the same cycle would race the sequencer
   assign do_wr = io_wr_i;
   assign do_rd = io_rd_i && !io_wr_i;

   // ========================================================================
   // host-visible state
   // ========================================================================
   reg [7:0] mask_q; // pixel index mask
   reg [7:0] rd_idx_q; // entry being read
   reg [7:0] wr_idx_q; // entry being written
   reg [1:0] rd_seq_q; // next byte to read
   reg [1:0] wr_seq_q; // next byte to write
   reg [1:0] state_q; // which index was written last
   reg [7:0] red_hold_q; // first written byte kept aside
   reg [7:0] green_hold_q; // second written byte kept aside
   reg [23:0] cursor_q [0:CURSOR_ENTRIES-1]; // alternate cursor colours

   wire [23:0] new_entry; // full entry once blue arrives
   wire entry_done; // third byte written this cycle
   wire table_we; // commit to main table
   wire [23:0] table_host_rd; // main table entry at read index
   wire [23:0] cursor_host_rd; // cursor entry at read index
   wire [23:0] host_entry; // entry the read index selects
   wire [2:0] cur_wr_idx; // cursor slot being written
   wire [2:0] cur_rd_idx; // cursor slot being read

   assign cur_wr_idx = wr_idx_q[2:0];
   assign cur_rd_idx = rd_idx_q[2:0];
   assign entry_done = do_wr && hit_data &&
                       (wr_seq_q == `VPL_SEQ_BLUE);
   assign new_entry = {red_hold_q, green_hold_q, io_wdata_i};
   assign table_we = entry_done && !cursor_select_i;
   assign cursor_host_rd = cursor_q[cur_rd_idx];
   assign host_entry = cursor_select_i ? cursor_host_rd :
                       table_host_rd;

   // ========================================================================
   // index, sequencer, mask and state registers
   // ========================================================================
   always @(posedge clock_i) begin
      if (sys_rst_i) begin
         mask_q <= `VPL_MASK_RST;
         rd_idx_q <= `VPL_IDX_RST;
         wr_idx_q <= `VPL_IDX_RST;
         rd_seq_q <= `VPL_SEQ_RED;
         wr_seq_q <= `VPL_SEQ_RED;
         state_q <= `VPL_STATE_WRITE;
         red_hold_q <= 8'h00;
         green_hold_q <= 8'h00;
      end else if (do_wr) begin
         if (hit_mask) begin
            mask_q <= io_wdata_i;
         end else if (hit_rd_idx) begin
            // loading an index restarts both sequences at red
            rd_idx_q <= io_wdata_i;
            rd_seq_q <= `VPL_SEQ_RED;
            wr_seq_q <= `VPL_SEQ_RED;
            state_q <= `VPL_STATE_READ;
         end else if (hit_wr_idx) begin
            wr_idx_q <= io_wdata_i;
            rd_seq_q <= `VPL_SEQ_RED;
            wr_seq_q <= `VPL_SEQ_RED;
            state_q <= `VPL_STATE_WRITE;
         end else if (hit_data) begin
            case (wr_seq_q)
               // red and green wait aside until blue completes the entry
               `VPL_SEQ_RED: begin
                  red_hold_q <= io_wdata_i;
                  wr_seq_q <= `VPL_SEQ_GREEN;
               end
               `VPL_SEQ_GREEN: begin
                  green_hold_q <= io_wdata_i;
                  wr_seq_q <= `VPL_SEQ_BLUE;
               end
               `VPL_SEQ_BLUE: begin
                  wr_seq_q <= `VPL_SEQ_RED;
                  wr_idx_q <= wr_idx_q + 8'h01;
               end
               default: begin
                  wr_seq_q <= `VPL_SEQ_RED;
               end
            endcase
         end
      end else if (do_rd && hit_data) begin
         // red, green, blue, then step to the next entry
         if (rd_seq_q == `VPL_SEQ_BLUE) begin
            rd_seq_q <= `VPL_SEQ_RED;
            rd_idx_q <= rd_idx_q + 8'h01;
         end else begin
            rd_seq_q <= rd_seq_q + 2'h1;
         end
      end
   end

   // ========================================================================
   // cursor entries; small enough to keep in flops
   // ========================================================================
   always @(posedge clock_i) begin
      if (entry_done && cursor_select_i) begin
         cursor_q[cur_wr_idx] <= new_entry;
      end
   end

   // ========================================================================
   // host read data, one cycle after the strobe
   // ========================================================================
   always @(posedge clock_i) begin
      if (sys_rst_i) begin
         io_rdata_o <= `VPL_RDATA_RST;
         io_rvalid_o <= 1'b0;
      end else begin
         io_rvalid_o <= do_rd;
         if (do_rd) begin
            if (hit_data) begin
               io_rdata_o <= pick_byte(host_entry, rd_seq_q);
            end else if (hit_mask) begin
               io_rdata_o <= mask_q;
            end else if (hit_rd_idx) begin
               io_rdata_o <= {6'h00, state_q};
            end else begin
               // write-only and unmapped addresses read as zero
               io_rdata_o <= 8'h00;
            end
         end
      end
   end

   // ========================================================================
   // pixel path: buffer, lookup, registered converter codes
   // ========================================================================
   wire fifo_valid; // buffered pixel available
   wire fifo_pop; // pixel taken into the output stage
   wire [24:0] fifo_word; // mode bit with pixel
   wire [7:0] pix_index; // masked table index
   wire [23:0] pix_entry; // looked-up colour
   wire stage_free; // output stage can accept

   // the mode travels with each pixel so a mode change is pixel-exact
   vpl_fifo #(
      .WIDTH(25),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_fifo (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .in_valid_i(pix_valid_i),
      .in_ready_o(pix_ready_o),
      .in_data_i({direct_mode_i, pix_data_i}),
      .out_valid_o(fifo_valid),
      .out_ready_i(stage_free),
      .out_data_o(fifo_word)
   );

   vpl_color_ram #(
      .ENTRIES(ENTRIES),
      .AW(8),
      .DW(24)
   ) u_table (
      .clock_i(clock_i),
      .wr_en_i(table_we),
      .wr_addr_i(wr_idx_q),
      .wr_data_i(new_entry),
      .pix_addr_i(pix_index),
      .pix_data_o(pix_entry),
      .host_addr_i(rd_idx_q),
      .host_data_o(table_host_rd)
   );

   // downstream back-pressure reaches the buffer and then the source
   assign stage_free = !dac_valid_o || dac_ready_i;
   assign fifo_pop = fifo_valid && stage_free;
   assign pix_index = fifo_word[7:0] & mask_q;

   // ========================================================================
   // output register; held while the converters stall
   // ========================================================================
   always @(posedge clock_i) begin
      if (sys_rst_i) begin
         dac_valid_o <= 1'b0;
         dac_red_o <= 8'h00;
         dac_green_o <= 8'h00;
         dac_blue_o <= 8'h00;
      end else if (stage_free) begin
         dac_valid_o <= fifo_valid;
         if (fifo_pop) begin
            if (fifo_word[24]) begin
               // preformatted pixel bits, mask not applied
               dac_red_o <= fifo_word[`VPL_RED_LSB +: 8];
               dac_green_o <= fifo_word[`VPL_GREEN_LSB +: 8];
               dac_blue_o <= fifo_word[`VPL_BLUE_LSB +: 8];
            end else begin
               dac_red_o <= pix_entry[`VPL_RED_LSB +: 8];
               dac_green_o <= pix_entry[`VPL_GREEN_LSB +: 8];
               dac_blue_o <= pix_entry[`VPL_BLUE_LSB +: 8];
            end
         end
      end
   end

endmodule

/* File: common/vpl_regs.vh */
// register map, reset values and field layout of the palette lookup block
// assumes a byte-wide host i/o port and a 24-bit pixel word upstream
`ifndef VPL_REGS_VH
`define VPL_REGS_VH

// ==========================================================================
// host port addresses
// ==========================================================================
`define VPL_ADDR_MASK     16'h03C6
`define VPL_ADDR_RD_IDX   16'h03C7
`define VPL_ADDR_WR_IDX   16'h03C8
`define VPL_ADDR_DATA_IO  16'h03C9
`define VPL_ADDR_DATA_MEM 16'h03C1

// ==========================================================================
// reset values
// ==========================================================================
`define VPL_MASK_RST      8'hFF
`define VPL_IDX_RST       8'h00
`define VPL_RDATA_RST     8'h00

// ==========================================================================
// index state field codes
// ==========================================================================
`define VPL_STATE_WRITE   2'h0
`define VPL_STATE_READ    2'h3

// ==========================================================================
// byte sequencer steps
// ==========================================================================
`define VPL_SEQ_RED       2'h0
`define VPL_SEQ_GREEN     2'h1
`define VPL_SEQ_BLUE      2'h2

// ==========================================================================
// field positions inside a 24-bit colour word
// ==========================================================================
`define VPL_RED_LSB       16
`define VPL_GREEN_LSB     8
`define VPL_BLUE_LSB      0

`endif

/* File: rtl/vpl_fifo.v */
// synchronous first-in first-out buffer with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps

module vpl_fifo #(
   parameter WIDTH = 25,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clock_i,
   input wire sys_rst_i,
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [WIDTH-1:0] in_data_i,
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);

   // ========================================================================
   // storage and pointers
   // ========================================================================
   reg [WIDTH-1:0] mem_q [0:DEPTH-1]; // word storage, no reset needed
   reg [AW-1:0] wr_ptr_q; // next slot to fill
   reg [AW-1:0] rd_ptr_q; // oldest word
   reg [AW:0] count_q; // words held
   wire push; // word accepted this cycle
   wire pop; // word drained this cycle

   localparam [AW:0] DEPTH_W = DEPTH[AW:0];
   localparam [AW-1:0] LAST_PTR = DEPTH[AW-1:0] - 1'b1;

   assign in_ready_o = (count_q != DEPTH_W);
   assign out_valid_o = (count_q != {(AW+1){1'b0}});
   assign out_data_o = mem_q[rd_ptr_q];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // ========================================================================
   // data write, no reset so it maps to plain ram
   // ========================================================================
   always @(posedge clock_i) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data_i;
      end
   end

   // ========================================================================
   // pointers wrap explicitly so depth need not be a power of two
   // ========================================================================
   always @(posedge clock_i) begin
      if (sys_rst_i) begin
         wr_ptr_q <= {AW{1'b0}};
         rd_ptr_q <= {AW{1'b0}};
         count_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == LAST_PTR) ? {AW{1'b0}} :
                        wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == LAST_PTR) ? {AW{1'b0}} :
                        rd_ptr_q + 1'b1;
         end
         if (push && !pop) begin
            count_q <= count_q + 1'b1;
         end else if (pop && !push) begin
            count_q <= count_q - 1'b1;
         end
      end
   end

endmodule

/* File: rtl/vpl_color_ram.v */
// colour table storage: one write port, two asynchronous read ports
// assumes contents are undefined after power-up, as software loads them
`timescale 1ns/1ps

module vpl_color_ram #(
   parameter ENTRIES = 256,
   parameter AW = 8,
   parameter DW = 24
) (
   input wire clock_i,
   input wire wr_en_i,
   input wire [AW-1:0] wr_addr_i,
   input wire [DW-1:0] wr_data_i,
   input wire [AW-1:0] pix_addr_i,
   output wire [DW-1:0] pix_data_o,
   input wire [AW-1:0] host_addr_i,
   output wire [DW-1:0] host_data_o
);

   // ========================================================================
   // storage
   // ========================================================================
   reg [DW-1:0] mem_q [0:ENTRIES-1]; // colour entries

   // pixel side and host side read independently
   assign pix_data_o = mem_q[pix_addr_i];
   assign host_data_o = mem_q[host_addr_i];

   // ========================================================================
   // whole-entry write only
   // ========================================================================
   always @(posedge clock_i) begin
      if (wr_en_i) begin
         mem_q[wr_addr_i] <= wr_data_i;
      end
   end

endmodule

/* File: verif/vpl_lookup_properties.sv */
// checker: host port and pixel output timing of the palette lookup block
// assumes it is bound to vpl_lookup_top and sees only that module's ports
`timescale 1ns/1ps
module vpl_lookup_props (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic [15:0] io_addr_i,
   input wire logic io_wr_i,
   input wire logic io_rd_i,
   input wire logic [7:0] io_wdata_i,
   input wire logic [7:0] io_rdata_o,
   input wire logic io_rvalid_o,
   input wire logic pix_valid_i,
   input wire logic pix_ready_o,
   input wire logic dac_valid_o,
   input wire logic dac_ready_i,
   input wire logic [7:0] dac_red_o,
   input wire logic [7:0] dac_green_o,
   input wire logic [7:0] dac_blue_o
);
   // ======================================================================
   // host access steps
   // ======================================================================
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (sys_rst_i);
   // an accepted write at one address
   sequence s_wr(a);
      io_wr_i && io_addr_i == a;
   endsequence
   // an accepted read: a write in the same cycle wins
   sequence s_rd(a);
      io_rd_i && !io_wr_i && io_addr_i == a;
   endsequence
   // ======================================================================
   // host port answers
   // ======================================================================
   a_read_answer: assert property (io_rd_i && !io_wr_i |=> io_rvalid_o)
      else $error("read got no answer");
   a_no_stray_answer: assert property (
      !(io_rd_i && !io_wr_i) |=> !io_rvalid_o)
      else $error("answer without a read");
   a_rdata_holds: assert property (!io_rvalid_o |-> $stable(io_rdata_o))
      else $error("read data moved without a read");
   a_mask_readback: assert property (
      s_wr(16'h03C6) ##1 s_rd(16'h03C6) |=> io_rdata_o == $past(io_wdata_i, 2))
      else $error("mask read differs from last write");
   a_state_read_idx: assert property (
      s_wr(16'h03C7) ##1 s_rd(16'h03C7) |=> io_rdata_o == 8'h03)
      else $error("state not 11 after read index write");
   a_state_write_idx: assert property (
      s_wr(16'h03C8) ##1 s_rd(16'h03C7) |=> io_rdata_o == 8'h00)
      else $error("state not 00 after write index write");
   a_wr_idx_unread: assert property (
      s_rd(16'h03C8) |=> io_rdata_o == 8'h00)
      else $error("write index is not write only");
   // ======================================================================
   // pixel output
   // ======================================================================
   a_dac_holds: assert property (
      dac_valid_o && !dac_ready_i |=> dac_valid_o &&
      $stable({dac_red_o, dac_green_o, dac_blue_o}))
      else $error("codes moved while stalled");
   a_pixel_answered: assert property (
      pix_valid_i && pix_ready_o |-> ##[1:100] dac_valid_o)
      else $error("pushed pixel gave no codes");
endmodule

bind vpl_lookup_top vpl_lookup_props u_props (.clock_i, .sys_rst_i,
   .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i, .io_rdata_o, .io_rvalid_o,
   .pix_valid_i, .pix_ready_o, .dac_valid_o, .dac_ready_i, .dac_red_o,
   .dac_green_o, .dac_blue_o);

/* File: verif/vpl_dac_sink.sv */
// stand-in for the converters downstream of the codes
// assumes the bench picks the stall mode; moves only at the falling edge
`timescale 1ns/1ps
module vpl_dac_sink (
   input wire logic clock_i,
   input wire logic [1:0] mode_i,
   output logic ready_o
);
   // ======================================================================
   // stall pattern
   // ======================================================================
   logic [7:0] lfsr_q = 8'hA5; // irregular but repeatable pattern
   initial ready_o = 1'b1;
   // falling edge keeps ready clear of the sampling edge
   always @(negedge clock_i) begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      case (mode_i)
         2'h0: ready_o <= 1'b1; // always free
         2'h1: ready_o <= lfsr_q[0]; // slow: random stalls
         default: ready_o <= 1'b0; // held off, fills the buffer
      endcase
   end
endmodule

/* File: verif/tb_vga_palette_lookup.sv */
// self-checking bench for the palette lookup block with a reference model
// assumes vpl_regs.vh is on the include path; inputs move at falling edges
`timescale 1ns/1ps
`include "vpl_regs.vh"
module tb_vga_palette_lookup;
   // ======================================================================
   // stimulus and model state
   // ======================================================================
   logic clock_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [15:0] io_addr_i = 16'h0000;
   logic io_mem_space_i = 1'b0;
   logic io_wr_i = 1'b0;
   logic io_rd_i = 1'b0;
   logic [7:0] io_wdata_i = 8'h00;
   logic cursor_select_i = 1'b0;
   logic direct_mode_i = 1'b0;
   logic pix_valid_i = 1'b0;
   logic [23:0] pix_data_i = 24'h000000;
   logic [1:0] sink_mode = 2'h0;
   wire [7:0] io_rdata_o, dac_red_o, dac_green_o, dac_blue_o;
   wire io_rvalid_o, pix_ready_o, dac_valid_o, dac_ready_i;
   logic [23:0] pal [0:255]; // model of the main table
   logic [23:0] cur [0:7]; // model of the cursor entries
   logic [7:0] msk = 8'hFF, rdx = 8'h00, wdx = 8'h00;
   logic [1:0] st = 2'h0; // last index written
   logic [23:0] wb; // partial colour held until blue
   logic [23:0] expq [$]; // codes owed by the pixel path
   int rs = 0, ws = 0, i, n, n_fail = 0, num_checks = 0;
   integer seed = 32'ha9c3;

   always #50 clock_i = ~clock_i;

   vpl_lookup_top uut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
      .io_addr_i(io_addr_i), .io_mem_space_i(io_mem_space_i),
      .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i),
      .io_rdata_o(io_rdata_o), .io_rvalid_o(io_rvalid_o),
      .cursor_select_i(cursor_select_i), .direct_mode_i(direct_mode_i),
      .pix_valid_i(pix_valid_i), .pix_ready_o(pix_ready_o),
      .pix_data_i(pix_data_i), .dac_valid_o(dac_valid_o),
      .dac_ready_i(dac_ready_i), .dac_red_o(dac_red_o),
      .dac_green_o(dac_green_o), .dac_blue_o(dac_blue_o));
   vpl_dac_sink u_sink (.clock_i(clock_i), .mode_i(sink_mode),
      .ready_o(dac_ready_i));

   // ======================================================================
   // reporting
   // ======================================================================
   task automatic fail(input string m);
      n_fail++;
      $display("wrong value at %0t: %s", $time, m);
   endtask
   task automatic chk_bit(input logic g, input logic e);
      num_checks++;
      if (g !== e) fail($sformatf("flag %b, expected %b", g, e));
   endtask
   task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
      num_checks++;
      if (g !== e) fail($sformatf("byte %h, expected %h", g, e));
   endtask
   task automatic chk_rgb(input logic [23:0] g, input logic [23:0] e);
      num_checks++;
      if (g !== e) fail($sformatf("rgb %h, expected %h", g, e));
   endtask
   task automatic end_of_test;
      $display("checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // ======================================================================
   // host access: strobes stay up so back-to-back calls need one edge each
   // ======================================================================
   task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
      logic dp;
      logic [7:0] e;
      logic [23:0] ent;
      dp = (a == (io_mem_space_i ? `VPL_ADDR_DATA_MEM : `VPL_ADDR_DATA_IO));
      ent = cursor_select_i ? cur[rdx[2:0]] : pal[rdx];
      e = 8'h00;
      if (w) begin
         if (a == `VPL_ADDR_MASK) msk = d;
         if (a == `VPL_ADDR_RD_IDX || a == `VPL_ADDR_WR_IDX) begin
            // any index write restarts both byte sequencers at red
            rs = 0;
            ws = 0;
            st = (a == `VPL_ADDR_RD_IDX) ? 2'h3 : 2'h0;
            if (a == `VPL_ADDR_RD_IDX) rdx = d;
            else wdx = d;
         end
         if (dp) begin
            wb = {wb[15:0], d};
            ws++;
         end
         if (ws == 3) begin
            // whole colour lands at once, then the index moves on
            if (cursor_select_i) cur[wdx[2:0]] = wb;
            else pal[wdx] = wb;
            wdx++;
            ws = 0;
         end
      end else begin
         if (a == `VPL_ADDR_MASK) e = msk;
         if (a == `VPL_ADDR_RD_IDX) e = {6'h00, st};
         if (dp) begin
            e = ent[8*(2-rs) +: 8];
            rs++;
         end
         if (rs == 3) begin
            rs = 0;
            rdx++;
         end
      end
      io_addr_i = a;
      io_wdata_i = d;
      io_wr_i = w;
      io_rd_i = !w;
      @(negedge clock_i);
      if (!w) begin
         chk_bit(io_rvalid_o, 1'b1);
         chk_byte(io_rdata_o, e);
      end
   endtask
   // three data port bytes, random when written
   task automatic seq3(input logic w, input logic [15:0] a);
      for (int k = 0; k < 3; k++) acc(w, a, 8'($random(seed)));
   endtask

   // ======================================================================
   // pixel path: hold valid until taken, then compare every result
   // ======================================================================
   task automatic push(input logic [23:0] p, input logic dm);
      int t;
      pix_data_i = p;
      direct_mode_i = dm;
      pix_valid_i = 1'b1;
      t = 0;
      @(posedge clock_i);
      while (!pix_ready_o && t < 200) begin
         @(posedge clock_i);
         t++;
      end
      if (t == 200) begin
         fail("pixel never taken");
         end_of_test;
      end
      @(negedge clock_i);
   endtask
   task automatic drain;
      int t;
      for (t = 0; t < 2000 && expq.size() > 0; t++) @(negedge clock_i);
      if (expq.size() > 0) begin
         fail("pixels lost");
         end_of_test;
      end
   endtask
   always @(posedge clock_i) begin
      if (!sys_rst_i && pix_valid_i && pix_ready_o)
         expq.push_back(direct_mode_i ? pix_data_i : pal[pix_data_i[7:0]&msk]);
      if (!sys_rst_i && dac_valid_o && dac_ready_i) begin
         if (expq.size() == 0) fail("codes without a pixel");
         else chk_rgb({dac_red_o, dac_green_o, dac_blue_o},
            expq.pop_front());
      end
   end

   // ======================================================================
   // main sequence
   // ======================================================================
   initial begin
      repeat (20) @(negedge clock_i);
      sys_rst_i = 1'b0;
      acc(0, `VPL_ADDR_MASK, 0);
      acc(0, `VPL_ADDR_RD_IDX, 0);
      acc(0, `VPL_ADDR_WR_IDX, 0);
      acc(1, 16'h03C5, 8'h77);
      acc(0, 16'h03C5, 0);
      acc(1, `VPL_ADDR_MASK, 8'h5A);
      acc(0, `VPL_ADDR_MASK, 0);
      acc(1, `VPL_ADDR_RD_IDX, 8'h00);
      acc(0, `VPL_ADDR_RD_IDX, 0);
      acc(1, `VPL_ADDR_WR_IDX, 8'h00);
      acc(0, `VPL_ADDR_RD_IDX, 0);
      for (i = 0; i < 256; i++) seq3(1, `VPL_ADDR_DATA_IO);
      acc(1, `VPL_ADDR_RD_IDX, 8'h00);
      for (i = 0; i < 256; i++) seq3(0, `VPL_ADDR_DATA_IO);
      // partial write is dropped by an index write
      acc(1, `VPL_ADDR_WR_IDX, 8'h09);
      acc(1, `VPL_ADDR_DATA_IO, 8'hAA);
      acc(1, `VPL_ADDR_RD_IDX, 8'h05);
      acc(0, `VPL_ADDR_DATA_IO, 0);
      acc(1, `VPL_ADDR_RD_IDX, 8'h09);
      seq3(0, `VPL_ADDR_DATA_IO);
      // interleaved reads and writes at different entries
      acc(1, `VPL_ADDR_WR_IDX, 8'h14);
      acc(1, `VPL_ADDR_RD_IDX, 8'h28);
      for (i = 0; i < 6; i++)
         acc(i[0], `VPL_ADDR_DATA_IO, 8'($random(seed)));
      io_mem_space_i = 1'b1;
      acc(1, `VPL_ADDR_WR_IDX, 8'h32);
      seq3(1, `VPL_ADDR_DATA_MEM);
      acc(1, `VPL_ADDR_RD_IDX, 8'h32);
      seq3(0, `VPL_ADDR_DATA_MEM);
      io_mem_space_i = 1'b0;
      // cursor entries use only the low index bits
      cursor_select_i = 1'b1;
      acc(1, `VPL_ADDR_WR_IDX, 8'h0B);
      seq3(1, `VPL_ADDR_DATA_IO);
      acc(1, `VPL_ADDR_RD_IDX, 8'h0B);
      seq3(0, `VPL_ADDR_DATA_IO);
      cursor_select_i = 1'b0;
      acc(1, `VPL_ADDR_RD_IDX, 8'h0B);
      seq3(0, `VPL_ADDR_DATA_IO);
      // direct and indexed pixels under several masks
      for (n = 0; n < 4; n++) begin
         acc(1, `VPL_ADDR_MASK, n == 0 ? 8'hFF : 8'($random(seed)));
         io_wr_i = 1'b0;
         sink_mode = n[0] ? 2'h1 : 2'h0;
         repeat (40) push(24'($random(seed)), 1'($random(seed)));
         pix_valid_i = 1'b0;
         drain;
      end
      // stalled converter: buffer fills and refuses, then drains
      sink_mode = 2'h2;
      n = 0;
      while (pix_ready_o === 1'b1 && n < 40) begin
         push(24'($random(seed)), 1'b1);
         n++;
      end
      pix_valid_i = 1'b0;
      chk_bit(pix_ready_o, 1'b0);
      sink_mode = 2'h1;
      drain;
      chk_bit(pix_ready_o, 1'b1);
      end_of_test;
   end
endmodule
